// >>> logic/mre_consts.svh
`ifndef MRE_CONSTS_SVH
`define MRE_CONSTS_SVH

// Widths of the instruction word, file address, data and program counter.
`define MRE_INSTR_W 14
`define MRE_FADDR_W 7
`define MRE_DATA_W 8
`define MRE_PC_W 13

// Field positions inside the instruction word.
`define MRE_DEST_BIT 7
`define MRE_FADDR_LSB 0
`define MRE_LIT_LSB 0

// Bit position of the global interrupt enable in the interrupt control register.
`define MRE_INT_ENABLE_BIT 7

// Opcode match patterns and masks.
`define MRE_MOVE_FILE_MASK 14'h3F00
`define MRE_MOVE_FILE_PAT 14'h0800
`define MRE_MOVE_WF_MASK 14'h3F80
`define MRE_MOVE_WF_PAT 14'h0080
`define MRE_MOVE_LIT_MASK 14'h3C00
`define MRE_MOVE_LIT_PAT 14'h3000
`define MRE_NO_OP_MASK 14'h3F9F
`define MRE_NO_OP_PAT 14'h0000
`define MRE_RETI_MASK 14'h3FFF
`define MRE_RETI_PAT 14'h0009

// Instruction cycle counts.
`define MRE_RETI_CYCLES 2
`define MRE_SINGLE_CYCLES 1

// Reset values.
`define MRE_WORK_RST 8'h00
`define MRE_PC_RST 13'h0000

`endif

// >>> logic/mre_pkg.sv
`default_nettype none
package mre_pkg;

    // Decoded operation classes.
    typedef enum logic [5:0] {
        OP_NONE = 6'h01,
        OP_MOVE_FILE = 6'h02,
        OP_MOVE_WF = 6'h04,
        OP_MOVE_LIT = 6'h08,
        OP_NO_OPERATION = 6'h10,
        OP_RETI = 6'h20
    } mre_op_e;

    // Executor states, one-hot.
    typedef enum logic [1:0] {
        ST_EXEC = 2'h1,
        ST_RETI2 = 2'h2
    } mre_state_e;

endpackage : mre_pkg
`default_nettype wire

// >>> logic/mre_decode.sv
`timescale 1ns/1ps
`default_nettype none
`include "mre_consts.svh"

module mre_decode (
    input wire logic [`MRE_INSTR_W-1:0] instrWord, // Instruction word to decode.
    output mre_pkg::mre_op_e op, // Decoded operation class.
    output logic destFile, // Destination bit, 1 selects the file register.
    output logic [`MRE_FADDR_W-1:0] fileAddr, // File register address field.
    output logic [`MRE_DATA_W-1:0] literal // Immediate literal field.
);

    // Fields are pulled out unconditionally; only the op class says which are meaningful.
    assign destFile = instrWord[`MRE_DEST_BIT];
    assign fileAddr = instrWord[`MRE_FADDR_LSB +: `MRE_FADDR_W];
    assign literal = instrWord[`MRE_LIT_LSB +: `MRE_DATA_W];

    // Pattern match against each supported opcode; anything else is reported as none.
    always_comb begin
        op = mre_pkg::OP_NONE;
        if ((instrWord & `MRE_RETI_MASK) == `MRE_RETI_PAT) begin
            op = mre_pkg::OP_RETI;
        end else if ((instrWord & `MRE_MOVE_FILE_MASK) == `MRE_MOVE_FILE_PAT) begin
            op = mre_pkg::OP_MOVE_FILE;
        end else if ((instrWord & `MRE_MOVE_WF_MASK) == `MRE_MOVE_WF_PAT) begin
            op = mre_pkg::OP_MOVE_WF;
        end else if ((instrWord & `MRE_MOVE_LIT_MASK) == `MRE_MOVE_LIT_PAT) begin
            op = mre_pkg::OP_MOVE_LIT;
        end else if ((instrWord & `MRE_NO_OP_MASK) == `MRE_NO_OP_PAT) begin
            op = mre_pkg::OP_NO_OPERATION;
        end
    end

endmodule : mre_decode
`default_nettype wire

// >>> logic/mre_exec.sv
`timescale 1ns/1ps
`default_nettype none
`include "mre_consts.svh"

module mre_exec (
    input wire logic clock, // Core clock, 10 MHz.
    input wire logic rst, // Synchronous reset, active high.
    input wire logic instrValid, // Instruction word on instrWord is valid.
    input wire logic [`MRE_INSTR_W-1:0] instrWord, // Instruction word from fetch.
    output logic instrReady, // Executor can take an instruction this cycle.
    output logic [`MRE_FADDR_W-1:0] fileRdAddr, // File register read address.
    input wire logic [`MRE_DATA_W-1:0] fileRdData, // File register read data, same cycle.
    output logic fileWrEn, // File register write strobe.
    output logic [`MRE_FADDR_W-1:0] fileWrAddr, // File register write address.
    output logic [`MRE_DATA_W-1:0] fileWrData, // File register write data.
    output logic [`MRE_DATA_W-1:0] workingReg, // Working register contents.
    output logic zeroWrEn, // Zero flag update strobe.
    output logic zeroValue, // New zero flag value.
    input wire logic [`MRE_PC_W-1:0] stackTop, // Top of the hardware stack.
    output logic stackPop, // Stack pop strobe.
    output logic pcLoad, // Program counter load strobe.
    output logic [`MRE_PC_W-1:0] pcLoadValue, // Value to load into the program counter.
    output logic pcAdvance, // Program counter increment strobe.
    output logic intEnableSet, // Set global interrupt enable strobe.
    output logic instrDone, // Instruction completed this cycle.
    output logic illegalOp // Unsupported word was taken and treated as a no-op.
);

    ////////////////////////////////////////////////////////////////////////////
    // Decode.
    ////////////////////////////////////////////////////////////////////////////

    mre_pkg::mre_op_e op;
    logic destFile;
    logic [`MRE_FADDR_W-1:0] decAddr;
    logic [`MRE_DATA_W-1:0] decLiteral;
    logic take;

    // Splits the instruction word into operation class and operand fields.
    mre_decode mre_decode_i (
        .instrWord(instrWord),
        .op(op),
        .destFile(destFile),
        .fileAddr(decAddr),
        .literal(decLiteral)
    );

    // The file space is read combinationally from the address in the current word.
    assign fileRdAddr = decAddr;

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer.
    ////////////////////////////////////////////////////////////////////////////

    mre_pkg::mre_state_e state_reg;
    mre_pkg::mre_state_e state_next;

    // The second cycle of a return holds off the next word.
    assign instrReady = (state_reg == mre_pkg::ST_EXEC);
    assign take = instrValid && instrReady;

    // A return spends one extra cycle in the second state.
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            mre_pkg::ST_EXEC: begin
                if (take && (op == mre_pkg::OP_RETI)) begin
                    state_next = mre_pkg::ST_RETI2;
                end
            end
            mre_pkg::ST_RETI2: begin
                state_next = mre_pkg::ST_EXEC;
            end
            default: begin
                state_next = mre_pkg::ST_EXEC;
            end
        endcase
    end

    // Registers the sequencer state.
    always_ff @(posedge clock) begin
        if (rst) begin
            state_reg <= mre_pkg::ST_EXEC;
        end else begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Datapath and strobes.
    ////////////////////////////////////////////////////////////////////////////

    logic [`MRE_DATA_W-1:0] work_reg, work_next;
    logic fileWrEn_reg, fileWrEn_next;
    logic [`MRE_FADDR_W-1:0] fileWrAddr_reg, fileWrAddr_next;
    logic [`MRE_DATA_W-1:0] fileWrData_reg, fileWrData_next;
    logic zeroWrEn_reg, zeroWrEn_next;
    logic zeroValue_reg, zeroValue_next;
    logic stackPop_reg, stackPop_next;
    logic pcLoad_reg, pcLoad_next;
    logic [`MRE_PC_W-1:0] pcLoadValue_reg, pcLoadValue_next;
    logic pcAdvance_reg, pcAdvance_next;
    logic intEnableSet_reg, intEnableSet_next;
    logic instrDone_reg, instrDone_next;
    logic illegalOp_reg, illegalOp_next;

    // Works out the effect of the word being taken; strobes default to idle each cycle.
    always_comb begin
        work_next = work_reg;
        fileWrEn_next = 1'b0;
        fileWrAddr_next = fileWrAddr_reg;
        fileWrData_next = fileWrData_reg;
        zeroWrEn_next = 1'b0;
        zeroValue_next = zeroValue_reg;
        stackPop_next = 1'b0;
        pcLoad_next = 1'b0;
        pcLoadValue_next = pcLoadValue_reg;
        pcAdvance_next = 1'b0;
        intEnableSet_next = 1'b0;
        instrDone_next = 1'b0;
        illegalOp_next = 1'b0;
        if (state_reg == mre_pkg::ST_RETI2) begin
            instrDone_next = 1'b1;
        end
        if (take) begin
            case (op)
                mre_pkg::OP_MOVE_FILE: begin
                    if (destFile) begin
                        fileWrEn_next = 1'b1;
                        fileWrAddr_next = decAddr;
                        fileWrData_next = fileRdData;
                    end else begin
                        work_next = fileRdData;
                    end
                    zeroWrEn_next = 1'b1;
                    zeroValue_next = (fileRdData == `MRE_DATA_W'h00);
                    pcAdvance_next = 1'b1;
                    instrDone_next = 1'b1;
                end
                mre_pkg::OP_MOVE_WF: begin
                    fileWrEn_next = 1'b1;
                    fileWrAddr_next = decAddr;
                    fileWrData_next = work_reg;
                    pcAdvance_next = 1'b1;
                    instrDone_next = 1'b1;
                end
                mre_pkg::OP_MOVE_LIT: begin
                    work_next = decLiteral;
                    pcAdvance_next = 1'b1;
                    instrDone_next = 1'b1;
                end
                mre_pkg::OP_RETI: begin
                    stackPop_next = 1'b1;
                    pcLoad_next = 1'b1;
                    pcLoadValue_next = stackTop;
                    intEnableSet_next = 1'b1;
                end
                mre_pkg::OP_NO_OPERATION: begin
                    pcAdvance_next = 1'b1;
                    instrDone_next = 1'b1;
                end
                default: begin
                    // Unknown words behave as a no-op but are flagged.
                    pcAdvance_next = 1'b1;
                    instrDone_next = 1'b1;
                    illegalOp_next = 1'b1;
                end
            endcase
        end
    end

    // Registers the datapath and strobes.
    always_ff @(posedge clock) begin
        if (rst) begin
            work_reg <= `MRE_WORK_RST;
            fileWrEn_reg <= 1'b0;
            fileWrAddr_reg <= `MRE_FADDR_W'h00;
            fileWrData_reg <= `MRE_DATA_W'h00;
            zeroWrEn_reg <= 1'b0;
            zeroValue_reg <= 1'b0;
            stackPop_reg <= 1'b0;
            pcLoad_reg <= 1'b0;
            pcLoadValue_reg <= `MRE_PC_RST;
            pcAdvance_reg <= 1'b0;
            intEnableSet_reg <= 1'b0;
            instrDone_reg <= 1'b0;
            illegalOp_reg <= 1'b0;
        end else begin
            work_reg <= work_next;
            fileWrEn_reg <= fileWrEn_next;
            fileWrAddr_reg <= fileWrAddr_next;
            fileWrData_reg <= fileWrData_next;
            zeroWrEn_reg <= zeroWrEn_next;
            zeroValue_reg <= zeroValue_next;
            stackPop_reg <= stackPop_next;
            pcLoad_reg <= pcLoad_next;
            pcLoadValue_reg <= pcLoadValue_next;
            pcAdvance_reg <= pcAdvance_next;
            intEnableSet_reg <= intEnableSet_next;
            instrDone_reg <= instrDone_next;
            illegalOp_reg <= illegalOp_next;
        end
    end

    // Drives the outputs from the registers.
    assign workingReg = work_reg;
    assign fileWrEn = fileWrEn_reg;
    assign fileWrAddr = fileWrAddr_reg;
    assign fileWrData = fileWrData_reg;
    assign zeroWrEn = zeroWrEn_reg;
    assign zeroValue = zeroValue_reg;
    assign stackPop = stackPop_reg;
    assign pcLoad = pcLoad_reg;
    assign pcLoadValue = pcLoadValue_reg;
    assign pcAdvance = pcAdvance_reg;
    assign intEnableSet = intEnableSet_reg;
    assign instrDone = instrDone_reg;
    assign illegalOp = illegalOp_reg;

endmodule : mre_exec
`default_nettype wire

// >>> bench/mre_exec_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "mre_consts.svh"

module mre_exec_properties (
    input wire logic clock, // Core clock.
    input wire logic rst, // Reset.
    input wire logic instrValid, // Word valid.
    input wire logic [`MRE_INSTR_W-1:0] instrWord, // Word.
    input wire logic instrReady, // Ready.
    input wire logic [`MRE_DATA_W-1:0] fileRdData, // Read data.
    input wire logic fileWrEn, // Write strobe.
    input wire logic [`MRE_FADDR_W-1:0] fileWrAddr, // Write address.
    input wire logic [`MRE_DATA_W-1:0] fileWrData, // Write data.
    input wire logic [`MRE_DATA_W-1:0] workingReg, // Working register.
    input wire logic zeroWrEn, // Zero strobe.
    input wire logic zeroValue, // Zero value.
    input wire logic [`MRE_PC_W-1:0] stackTop, // Stack top.
    input wire logic stackPop, // Pop strobe.
    input wire logic pcLoad, // Load strobe.
    input wire logic [`MRE_PC_W-1:0] pcLoadValue, // Load value.
    input wire logic intEnableSet, // Enable strobe.
    input wire logic pcAdvance, // Advance strobe.
    input wire logic instrDone // Done strobe.
);
    ////////////////////////////////////////
    // Accepted words, split by operation class.
    logic take, isRet, isMoveFile, isMoveWf, isLit, isNoOp;
    assign take = instrValid && instrReady;
    assign isRet = take && ((instrWord & `MRE_RETI_MASK) == `MRE_RETI_PAT);
    assign isMoveFile = take && ((instrWord & `MRE_MOVE_FILE_MASK) == `MRE_MOVE_FILE_PAT);
    assign isMoveWf = take && ((instrWord & `MRE_MOVE_WF_MASK) == `MRE_MOVE_WF_PAT);
    assign isLit = take && ((instrWord & `MRE_MOVE_LIT_MASK) == `MRE_MOVE_LIT_PAT);
    assign isNoOp = take && ((instrWord & `MRE_NO_OP_MASK) == `MRE_NO_OP_PAT);

    default clocking @(posedge clock); endclocking
    default disable iff (rst);

    ////////////////////////////////////////
    a_ret_load_top: assert property (isRet |=> stackPop && pcLoad && pcLoadValue == $past(stackTop))
        else $error("return did not load the stack top");
    a_ret_sets_enable: assert property (isRet |=> intEnableSet && !zeroWrEn ##1 !intEnableSet)
        else $error("return did not pulse the enable set");
    a_ret_two_cycles: assert property (isRet |=> !instrReady && !instrDone ##1 instrDone && instrReady)
        else $error("return did not take two cycles");
    a_single_done: assert property ((isMoveFile || isMoveWf || isLit) |=> instrDone && pcAdvance && instrReady)
        else $error("move did not finish in one cycle");
    a_move_file_dest: assert property (isMoveFile |=> fileWrEn == $past(instrWord[`MRE_DEST_BIT])
        && (fileWrEn ? (fileWrData == $past(fileRdData)) : (workingReg == $past(fileRdData))))
        else $error("move file went to the wrong place");
    a_move_file_zero: assert property (isMoveFile |=> zeroWrEn && zeroValue == ($past(fileRdData) == 8'h00))
        else $error("move file zero flag wrong");
    a_copy_working: assert property (isMoveWf |=> fileWrEn && !zeroWrEn && fileWrData == $past(workingReg)
        && fileWrAddr == $past(instrWord[`MRE_FADDR_W-1:0]))
        else $error("move working to file wrong");
    a_lit_load: assert property (isLit |=> !zeroWrEn && workingReg == $past(instrWord[`MRE_DATA_W-1:0]))
        else $error("move literal wrong");
    a_idle_quiet: assert property (isNoOp |=> instrDone && !fileWrEn && !zeroWrEn && !stackPop && $stable(workingReg))
        else $error("no-operation changed state");

    // Main scenarios reached.
    c_ret: cover property (isRet ##2 take);
    c_zero_test: cover property (isMoveFile ##1 zeroValue && fileWrEn);
    c_lit_then_store: cover property (isLit ##1 isMoveWf);
endmodule : mre_exec_properties

bind mre_exec mre_exec_properties mre_exec_properties_i (.clock, .rst, .instrValid, .instrWord, .instrReady,
    .fileRdData, .fileWrEn, .fileWrAddr, .fileWrData, .workingReg, .zeroWrEn, .zeroValue, .stackTop,
    .stackPop, .pcLoad, .pcLoadValue, .intEnableSet, .pcAdvance, .instrDone);
`default_nettype wire

// >>> bench/move_and_return_instr_exec_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "mre_consts.svh"

module move_and_return_instr_exec_tb_top;
    logic clock, rst, instrValid, instrReady, fileWrEn, zeroWrEn, zeroValue;
    logic stackPop, pcLoad, pcAdvance, intEnableSet, instrDone, illegalOp;
    logic [13:0] instrWord;
    logic [6:0] fileRdAddr, fileWrAddr;
    logic [7:0] fileRdData, fileWrData, workingReg;
    logic [12:0] stackTop, pcLoadValue;
    int error_cnt = 0;
    int samples_checked = 0;
    int cycles = 0;

    mre_exec mre_exec_i (.clock, .rst, .instrValid, .instrWord, .instrReady, .fileRdAddr, .fileRdData,
        .fileWrEn, .fileWrAddr, .fileWrData, .workingReg, .zeroWrEn, .zeroValue, .stackTop, .stackPop,
        .pcLoad, .pcLoadValue, .pcAdvance, .intEnableSet, .instrDone, .illegalOp);

    ////////////////////////////////////////
    // Compares one value and reports a mismatch.
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value %s: expected %h, seen %h", what, exp, got);
        end
    endtask : chk

    // Compares the strobes as {write, zero, advance, done, pop, load, enable}.
    task automatic pulses(input logic [6:0] exp);
        chk("strobes", {9'h000, exp}, {9'h000, fileWrEn, zeroWrEn, pcAdvance, instrDone, stackPop, pcLoad, intEnableSet});
    endtask : pulses

    // Presents a word with its file data and steps into the cycle after the take edge.
    task automatic send(input logic [13:0] w, input logic [7:0] rd);
        instrValid = 1'b1;
        instrWord = w;
        fileRdData = rd;
        @(posedge clock);
        #1;
        fileRdData = ~rd; // The read data is only valid for the taken word.
    endtask : send

    ////////////////////////////////////////
    // Checks the quiet state after reset.
    task automatic t_reset();
        chk("working", 16'h0000, {8'h00, workingReg});
        chk("ready", 16'h0001, {15'h0000, instrReady});
        pulses(7'h00);
        $display("test reset done");
    endtask : t_reset

    // Back-to-back literal loads at both ends of the range.
    task automatic t_literal();
        logic [7:0] ks[3] = '{8'h00, 8'hFF, 8'h5A};
        foreach (ks[i]) begin
            send({6'h30, ks[i]}, 8'h00);
            chk("working", {8'h00, ks[i]}, {8'h00, workingReg});
            pulses(7'h18);
        end
        $display("test literal done");
    endtask : t_literal

    // Move file to working, back to itself as a zero test, and a zero read.
    task automatic t_move_file();
        send(14'h087F, 8'h81);
        chk("rdaddr", 16'h007F, {9'h000, fileRdAddr});
        chk("working", 16'h0081, {8'h00, workingReg});
        chk("zero", 16'h0000, {15'h0000, zeroValue});
        pulses(7'h38);
        send(14'h08AA, 8'h00);
        chk("wraddr", 16'h002A, {9'h000, fileWrAddr});
        chk("wrdata", 16'h0000, {8'h00, fileWrData});
        chk("working", 16'h0081, {8'h00, workingReg});
        chk("zero", 16'h0001, {15'h0000, zeroValue});
        pulses(7'h78);
        send(14'h0805, 8'h00);
        chk("working", 16'h0000, {8'h00, workingReg});
        $display("test move file done");
    endtask : t_move_file

    // Literal then store back to back, to the top address.
    task automatic t_move_working();
        send(14'h303C, 8'h00);
        send(14'h00FF, 8'hAA);
        chk("wraddr", 16'h007F, {9'h000, fileWrAddr});
        chk("wrdata", 16'h003C, {8'h00, fileWrData});
        pulses(7'h58);
        send(14'h0000, 8'h55);
        chk("working", 16'h003C, {8'h00, workingReg});
        pulses(7'h18);
        $display("test move working done");
    endtask : t_move_working

    // Unsupported word acts as a no-operation but is flagged; a no-operation with its don't-care bits set is legal.
    task automatic t_illegal();
        send(14'h3FFF, 8'h00);
        chk("illegal", 16'h0001, {15'h0000, illegalOp});
        chk("working", 16'h003C, {8'h00, workingReg});
        pulses(7'h18);
        send(14'h0060, 8'h00);
        chk("illegal", 16'h0000, {15'h0000, illegalOp});
        pulses(7'h18);
        $display("test illegal done");
    endtask : t_illegal

    // Return with a word held during its second cycle, which must be refused.
    task automatic t_return();
        stackTop = 13'h1ABC;
        send(14'h0009, 8'h00);
        stackTop = 13'h0543;
        instrWord = 14'h3077;
        pulses(7'h07);
        chk("pcvalue", 16'h1ABC, {3'h0, pcLoadValue});
        chk("ready", 16'h0000, {15'h0000, instrReady});
        @(posedge clock);
        #1;
        pulses(7'h08);
        chk("working", 16'h003C, {8'h00, workingReg});
        @(posedge clock);
        #1;
        instrValid = 1'b0;
        chk("working", 16'h0077, {8'h00, workingReg});
        $display("test return done");
    endtask : t_return

    // Reset in mid-run with a word held: the word is dropped, then taken at the first edge after release.
    task automatic t_mid_reset();
        @(posedge clock);
        #1;
        rst = 1'b1;
        instrValid = 1'b1;
        instrWord = 14'h3011;
        @(posedge clock);
        #1;
        rst = 1'b0;
        chk("working", 16'h0000, {8'h00, workingReg});
        chk("ready", 16'h0001, {15'h0000, instrReady});
        chk("illegal", 16'h0000, {15'h0000, illegalOp});
        pulses(7'h00);
        @(posedge clock);
        #1;
        instrValid = 1'b0;
        chk("working", 16'h0011, {8'h00, workingReg});
        pulses(7'h18);
        $display("test mid reset done");
    endtask : t_mid_reset

    ////////////////////////////////////////
    // Prints the counts and the verdict, then stops.
    task automatic conclude();
        $display("checks %0d, mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : conclude

    // Free-running 10 MHz clock.
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    // Cuts a hang short well past the expected run length.
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 400) begin
            error_cnt++;
            conclude();
        end
    end

    // Reset, then the scenarios in turn.
    initial begin
        rst = 1'b1;
        instrValid = 1'b0;
        instrWord = 14'h0000;
        fileRdData = 8'h00;
        stackTop = 13'h0000;
        repeat (6) @(posedge clock);
        #1;
        rst = 1'b0;
        t_reset();
        t_literal();
        t_move_file();
        t_move_working();
        t_illegal();
        t_return();
        t_mid_reset();
        conclude();
    end
endmodule : move_and_return_instr_exec_tb_top
`default_nettype wire
